// ### src/caorsx_consts.vh
`ifndef CAORSX_CONSTS_VH
`define CAORSX_CONSTS_VH
// Operation codes written to control register bits 3:0.
`define CAORSX_OP_NOP 4'h0
`define CAORSX_OP_ROTATE_RIGHT 4'h1
`define CAORSX_OP_SUB_REG 4'h2
`define CAORSX_OP_SUB_LIT 4'h3
`define CAORSX_OP_SUB_BORROW 4'h4
`define CAORSX_OP_SWAP 4'h5
`define CAORSX_OP_DIR_LOAD 4'h6
`define CAORSX_OP_XOR_LIT 4'h7
`define CAORSX_OP_XOR_REG 4'h8
`define CAORSX_OP_SLEEP 4'h9
// Register byte offsets on the bus.
`define CAORSX_REG_CTRL 8'h00
`define CAORSX_REG_OPERAND 8'h04
`define CAORSX_REG_ACC 8'h08
`define CAORSX_REG_STATUS 8'h0c
`define CAORSX_REG_DIR 8'h10
`define CAORSX_REG_FILE_BASE 8'h80
// Control register fields.
`define CAORSX_CTRL_GO 31
`define CAORSX_CTRL_DEST 8
// Status register bit positions.
`define CAORSX_ST_CARRY 0
`define CAORSX_ST_DIG_CARRY 1
`define CAORSX_ST_ZERO 2
`define CAORSX_ST_POWER_DOWN 3
`define CAORSX_ST_TIMEOUT 4
// Reset value and file memory depth.
`define CAORSX_DIR_RESET 8'hff
`define CAORSX_FILE_DEPTH 128
// Direction register selectors.
`define CAORSX_DIR_SEL_A 8'h05
`define CAORSX_DIR_SEL_B 8'h06
`define CAORSX_DIR_SEL_C 8'h07
// Watchdog prescaler terminal count.
`define CAORSX_WDOG_PRE_MAX 8'hff
`endif

// ### src/caorsx_sub8.v
`timescale 1ns/100ps
`include "caorsx_consts.vh"
// Eight-bit subtractor: minuend minus subtrahend minus inverted carry.
module caorsx_sub8 (
  // Operands.
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cin_i,
  // Results.
  output wire [7:0] diff_o,
  output wire carry_o,
  output wire dig_carry_o
);
  wire [8:0] full_sum;
  wire [4:0] low_sum;

  // Adds the ones complement plus carry in, so carry set means no borrow.
  assign full_sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, cin_i};
  assign low_sum = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, cin_i};
  assign diff_o = full_sum[7:0];
  assign carry_o = full_sum[8];
  assign dig_carry_o = low_sum[4];
endmodule // caorsx_sub8

// ### src/caorsx_alu.v
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "caorsx_consts.vh"
module caorsx_alu (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_i,
  // AXI4-Lite write address.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Watchdog clear strobe and direction outputs.
  output reg wdog_clear_o,
  output reg [7:0] port_a_direction_o,
  output reg [7:0] port_b_direction_o,
  output reg [7:0] port_c_direction_o
);
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] file_mem [0:`CAORSX_FILE_DEPTH-1];
  reg [7:0] acc_r;
  reg [3:0] op_r;
  reg dest_r;
  reg [6:0] faddr_r;
  reg [7:0] lit_r;
  reg carry_r, dig_carry_r, zero_r, power_down_flag_r, timeout_flag_r;
  reg [7:0] watchdog_counter_r, wdog_pre_r;
  reg go_r;
  reg aw_held_r, w_held_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire [7:0] fval;
  wire [7:0] sub_a, sub_d;
  wire sub_cin, sub_c, sub_dig_carry;
  reg [7:0] res;
  reg wr_res, set_c, set_dig_carry, set_z, res_c;
  wire wr_fire;
  wire [7:0] wa;

  assign fval = file_mem[faddr_r];

  // Shared subtractor; the literal form uses the immediate as minuend.
  assign sub_a = (op_r == `CAORSX_OP_SUB_LIT) ? lit_r : fval;
  assign sub_cin = (op_r == `CAORSX_OP_SUB_BORROW) ? carry_r : 1'b1;
  caorsx_sub8 u_sub (
    .a_i(sub_a),
    .b_i(acc_r),
    .cin_i(sub_cin),
    .diff_o(sub_d),
    .carry_o(sub_c),
    .dig_carry_o(sub_dig_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag selection for the operation in hand.
  always @* begin
    res = 8'h00;
    wr_res = 1'b0;
    set_c = 1'b0;
    set_dig_carry = 1'b0;
    set_z = 1'b0;
    res_c = carry_r;
    case (op_r)
      `CAORSX_OP_ROTATE_RIGHT: begin
        res = {carry_r, fval[7:1]};
        res_c = fval[0];
        wr_res = 1'b1;
        set_c = 1'b1;
      end
      `CAORSX_OP_SUB_REG, `CAORSX_OP_SUB_LIT, `CAORSX_OP_SUB_BORROW: begin
        res = sub_d;
        res_c = sub_c;
        wr_res = 1'b1;
        set_c = 1'b1;
        set_dig_carry = 1'b1;
        set_z = 1'b1;
      end
      `CAORSX_OP_SWAP: begin
        res = {fval[3:0], fval[7:4]};
        wr_res = 1'b1;
      end
      `CAORSX_OP_XOR_LIT: begin
        res = acc_r ^ lit_r;
        wr_res = 1'b1;
        set_z = 1'b1;
      end
      `CAORSX_OP_XOR_REG: begin
        res = acc_r ^ fval;
        wr_res = 1'b1;
        set_z = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write channel capture; address and data arrive in either order.
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wa = aw_addr_r;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Misaligned or unmapped register words answer with an error.
        s_axi_bresp <= (wa[7] || (wa[1:0] == 2'h0 &&
                        wa <= `CAORSX_REG_DIR)) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state: operands, accumulator, flags, watchdog, directions.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= 8'h00;
      op_r <= `CAORSX_OP_NOP;
      dest_r <= 1'b0;
      faddr_r <= 7'h00;
      lit_r <= 8'h00;
      go_r <= 1'b0;
      carry_r <= 1'b0;
      dig_carry_r <= 1'b0;
      zero_r <= 1'b0;
      power_down_flag_r <= 1'b1;
      timeout_flag_r <= 1'b1;
      watchdog_counter_r <= 8'h00;
      wdog_pre_r <= 8'h00;
      wdog_clear_o <= 1'b0;
      port_a_direction_o <= `CAORSX_DIR_RESET;
      port_b_direction_o <= `CAORSX_DIR_RESET;
      port_c_direction_o <= `CAORSX_DIR_RESET;
    end else begin
      go_r <= 1'b0;
      wdog_clear_o <= 1'b0;
      // Free-running watchdog with prescaler.
      if (wdog_pre_r == `CAORSX_WDOG_PRE_MAX) begin
        wdog_pre_r <= 8'h00;
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
      end else begin
        wdog_pre_r <= wdog_pre_r + 8'h01;
      end
      if (go_r) begin
        if (set_c)
          carry_r <= res_c;
        if (set_dig_carry)
          dig_carry_r <= sub_dig_carry;
        if (set_z)
          zero_r <= (res == 8'h00);
        if (wr_res && (!dest_r || op_r == `CAORSX_OP_SUB_LIT ||
                       op_r == `CAORSX_OP_XOR_LIT))
          acc_r <= res;
        if (op_r == `CAORSX_OP_DIR_LOAD) begin
          case (lit_r)
            `CAORSX_DIR_SEL_A: port_a_direction_o <= acc_r;
            `CAORSX_DIR_SEL_B: port_b_direction_o <= acc_r;
            `CAORSX_DIR_SEL_C: port_c_direction_o <= acc_r;
            default: port_a_direction_o <= port_a_direction_o;
          endcase
        end
        if (op_r == `CAORSX_OP_SLEEP) begin
          watchdog_counter_r <= 8'h00;
          wdog_pre_r <= 8'h00;
          timeout_flag_r <= 1'b1;
          power_down_flag_r <= 1'b0;
          wdog_clear_o <= 1'b1;
        end
      end
      // Software register writes; an operation in flight wins.
      if (wr_fire && !go_r) begin
        case (wa)
          `CAORSX_REG_CTRL: if (w_strb_r[0]) begin
            op_r <= w_data_r[3:0];
            dest_r <= w_data_r[`CAORSX_CTRL_DEST];
            go_r <= w_data_r[`CAORSX_CTRL_GO];
          end
          `CAORSX_REG_OPERAND: if (w_strb_r[0]) begin
            lit_r <= w_data_r[7:0];
            faddr_r <= w_data_r[6:0];
          end
          `CAORSX_REG_ACC: if (w_strb_r[0])
            acc_r <= w_data_r[7:0];
          `CAORSX_REG_STATUS: if (w_strb_r[0]) begin
            carry_r <= w_data_r[`CAORSX_ST_CARRY];
            dig_carry_r <= w_data_r[`CAORSX_ST_DIG_CARRY];
            zero_r <= w_data_r[`CAORSX_ST_ZERO];
          end
          default: acc_r <= acc_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File memory: bus writes and result write-back.
  always @(posedge sys_clk_i) begin
    if (go_r && wr_res && dest_r && op_r != `CAORSX_OP_SUB_LIT &&
        op_r != `CAORSX_OP_XOR_LIT)
      file_mem[faddr_r] <= res;
    else if (wr_fire && wa[7] && w_strb_r[0])
      file_mem[wa[6:0]] <= w_data_r[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered the cycle after address.
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr[7])
        s_axi_rdata <= {24'h000000, file_mem[s_axi_araddr[6:0]]};
      else begin
        case (s_axi_araddr)
          `CAORSX_REG_CTRL:
            s_axi_rdata <= {23'h000000, dest_r, 4'h0, op_r};
          `CAORSX_REG_OPERAND: s_axi_rdata <= {24'h000000, lit_r};
          `CAORSX_REG_ACC: s_axi_rdata <= {24'h000000, acc_r};
          `CAORSX_REG_STATUS:
            s_axi_rdata <= {16'h0000, watchdog_counter_r, 3'h0,
                            timeout_flag_r, power_down_flag_r, zero_r,
                            dig_carry_r, carry_r};
          `CAORSX_REG_DIR:
            s_axi_rdata <= {8'h00, port_c_direction_o,
                            port_b_direction_o, port_a_direction_o};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // caorsx_alu

// ### sim/caorsx_alu_sva.sv
`timescale 1ns/100ps
// Port-level checks of the bus handshakes and the execution side effects.
module caorsx_alu_sva (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_i,
  // Write channels.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels.
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Side outputs.
  input wire wdog_clear_o,
  input wire [7:0] port_b_direction_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // A response stands until it is taken.
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // A read answers one cycle after its request; a write one cycle after
  // both channels are held, so two cycles after a joint handshake.
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while answering");
  ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("error read data not zero");
  // Sleep gives one clear pulse, only after a bus write.
  wdog_pulse_a: assert property (wdog_clear_o |=> !wdog_clear_o)
    else $error("watchdog clear too long");
  wdog_cause_a: assert property (wdog_clear_o |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("watchdog clear without command");
  dir_cause_a: assert property (!$stable(port_b_direction_o) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
    else $error("direction changed without command");
  // Main scenarios reached.
  cover property (wdog_clear_o);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (!$stable(port_b_direction_o));
endmodule // caorsx_alu_sva

bind caorsx_alu caorsx_alu_sva u_sva (.sys_clk_i, .rst_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .wdog_clear_o, .port_b_direction_o);

// ### sim/caorsx_alu_tb_top.sv
`timescale 1ns/100ps
`include "caorsx_consts.vh"
// Bench that runs each operation but NOP over the register bus and checks results.
module caorsx_alu_tb_top;
  reg sys_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, wdog_clear_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_a_direction_o, port_b_direction_o, port_c_direction_o;
  integer n_fail = 0, checked = 0, cyc = 0, i, n_clr = 0;
  reg [31:0] rd;
  reg [1:0] rs;
  reg [10:0] e;
  reg [7:0] v;
  caorsx_alu DUT (.sys_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wdog_clear_o, .port_a_direction_o, .port_b_direction_o,
    .port_c_direction_o);
  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and a count of watchdog clear pulses.
  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (wdog_clear_o === 1'b1)
      n_clr = n_clr + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  // Compares and reports.
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Bus write, then two idle cycles so the operation can complete.
  task axw(input [7:0] a, input [31:0] d);
    reg ha, hw, hb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
        @(negedge sys_clk_i);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hb = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge sys_clk_i);
        if (ha) s_axi_awvalid <= 1'b0;
        if (hw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask
  // Bus read into rd and rs.
  task axr(input [7:0] a);
    reg ha, hr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
        @(negedge sys_clk_i);
        ha = s_axi_arvalid & s_axi_arready;
        hr = s_axi_rvalid;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge sys_clk_i);
        if (ha) s_axi_arvalid <= 1'b0;
      end
      // One idle edge so a following read never reassigns rready at once.
      s_axi_rready <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  // Expected {zero, digit carry, carry, result} of one operation.
  function [10:0] mdl(input [3:0] op, input [7:0] w, f, k, input [2:0] st);
    reg [8:0] t;
    reg [4:0] n;
    reg [7:0] m;
    reg b;
    begin
      m = (op == `CAORSX_OP_SUB_LIT) ? k : f;
      b = (op == `CAORSX_OP_SUB_BORROW) ? !st[0] : 1'b0;
      t = {1'b0, m} - w - b;
      n = {1'b0, m[3:0]} - w[3:0] - b;
      case (op)
        `CAORSX_OP_ROTATE_RIGHT: mdl = {st[2:1], f[0], st[0], f[7:1]};
        `CAORSX_OP_SWAP: mdl = {st, f[3:0], f[7:4]};
        `CAORSX_OP_XOR_LIT: mdl = {(w ^ k) == 8'h0, st[1:0], w ^ k};
        `CAORSX_OP_XOR_REG: mdl = {(w ^ f) == 8'h0, st[1:0], w ^ f};
        default: mdl = {t[7:0] == 8'h0, !n[4], !t[8], t[7:0]};
      endcase
    end
  endfunction
  // Loads operands, executes, checks both places and the flags.
  task run(input [3:0] op, input dv, input [7:0] w, f, k, input [2:0] st);
    reg lit;
    begin
      lit = (op == `CAORSX_OP_SUB_LIT) || (op == `CAORSX_OP_XOR_LIT);
      e = mdl(op, w, f, k, st);
      axw(`CAORSX_REG_ACC, {24'h0, w});
      axw(`CAORSX_REG_STATUS, {29'h0, st});
      axw(`CAORSX_REG_FILE_BASE + 8'h04, {24'h0, f});
      axw(`CAORSX_REG_OPERAND, lit ? {24'h0, k} : 32'h4);
      axw(`CAORSX_REG_CTRL, {1'b1, 22'h0, dv, 4'h0, op});
      axr(`CAORSX_REG_ACC);
      chk(rd[7:0], (dv && !lit) ? w : e[7:0]);
      axr(`CAORSX_REG_FILE_BASE + 8'h04);
      chk(rd[7:0], (dv && !lit) ? e[7:0] : f);
      axr(`CAORSX_REG_STATUS);
      chk(rd[7:0] & 8'h07, {5'h0, e[10:8]});
    end
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(port_c_direction_o, `CAORSX_DIR_RESET);
    axr(`CAORSX_REG_STATUS);
    chk(rd[7:0] & 8'h18, 8'h18);
    run(`CAORSX_OP_ROTATE_RIGHT, 1'b1, 8'h3c, 8'h81, 8'h00, 3'b000);
    run(`CAORSX_OP_ROTATE_RIGHT, 1'b0, 8'h3c, 8'h02, 8'h00, 3'b111);
    run(`CAORSX_OP_SUB_REG, 1'b0, 8'h05, 8'h05, 8'h00, 3'b000);
    run(`CAORSX_OP_SUB_REG, 1'b1, 8'h06, 8'h05, 8'h00, 3'b111);
    run(`CAORSX_OP_SUB_LIT, 1'b1, 8'h1f, 8'h00, 8'h20, 3'b000);
    run(`CAORSX_OP_SUB_BORROW, 1'b1, 8'h01, 8'h03, 8'h00, 3'b000);
    run(`CAORSX_OP_SUB_BORROW, 1'b0, 8'h03, 8'h03, 8'h00, 3'b001);
    run(`CAORSX_OP_SWAP, 1'b1, 8'h3c, 8'ha5, 8'h00, 3'b101);
    run(`CAORSX_OP_XOR_LIT, 1'b1, 8'hff, 8'h00, 8'hff, 3'b011);
    run(`CAORSX_OP_XOR_REG, 1'b0, 8'h0f, 8'hf0, 8'h00, 3'b100);
    run(`CAORSX_OP_XOR_REG, 1'b1, 8'h3c, 8'h3c, 8'h00, 3'b011);
    for (i = 4; i < 8; i = i + 1) begin
      v = i[3:0] * 8'h11;
      axw(`CAORSX_REG_ACC, {24'h0, v});
      axw(`CAORSX_REG_OPERAND, {28'h0, v[3:0]});
      axw(`CAORSX_REG_CTRL, {1'b1, 27'h0, `CAORSX_OP_DIR_LOAD});
    end
    chk(port_a_direction_o, 8'h55);
    chk(port_b_direction_o, 8'h66);
    axr(`CAORSX_REG_DIR);
    chk(rd[23:16], 8'h77);
    axr(8'h40);
    chk({6'h0, rs}, 8'h02);
    // A misaligned, unmapped write must be answered with an error.
    axw(8'h42, 32'h0);
    chk({6'h0, rs}, 8'h02);
    // The free-running watchdog has advanced before the sleep clears it.
    axr(`CAORSX_REG_STATUS);
    chk({7'h0, rd[15:8] != 8'h00}, 8'h01);
    axw(`CAORSX_REG_CTRL, {1'b1, 27'h0, `CAORSX_OP_SLEEP});
    axr(`CAORSX_REG_STATUS);
    chk(rd[7:0] & 8'h18, 8'h10);
    chk(rd[15:8], 8'h00);
    chk(n_clr[7:0], 8'h01);
    report_and_stop;
  end
endmodule // caorsx_alu_tb_top
